// ### hw/adc_limit_pkg.sv
package adc_limit_pkg;
  // widths
  localparam int DATA_W = 12;
  localparam int ADDR_W = 5;
  localparam int WADDR_W = 4;
  localparam int FRAME_W = 16;
  localparam int CHAN_W = 4;
  localparam int SLOT_N = 4;

  // write addresses of the host frame
  localparam logic [WADDR_W-1:0] WADDR_NOP = 4'h0;
  localparam logic [WADDR_W-1:0] WADDR_CONV_CONTROL = 4'h1;
  localparam logic [WADDR_W-1:0] WADDR_CONV_SETUP = 4'h2;
  localparam logic [WADDR_W-1:0] WADDR_LIMIT_FIRST = 4'h4;
  localparam logic [WADDR_W-1:0] WADDR_LIMIT_LAST = 4'hb;
  localparam logic [WADDR_W-1:0] WADDR_ALERT = 4'hc;

  // readback addresses
  localparam logic [ADDR_W-1:0] RADDR_RESULT_BASE = 5'h10;

  // reset values
  localparam logic [DATA_W-1:0] CONV_CONTROL_RESET = 12'h000;
  localparam logic [DATA_W-1:0] CONV_SETUP_RESET = 12'h000;
  localparam logic [DATA_W-1:0] LIMIT_RESET = 12'h000;

  // conversion_control fields
  localparam int CC_SERDIF_BIT = 11;
  localparam int CC_CHAN_HI = 10;
  localparam int CC_CHAN_LO = 7;
  localparam int CC_RDADDR_HI = 6;
  localparam int CC_RDADDR_LO = 2;
  localparam int CC_MODE_HI = 1;
  localparam int CC_MODE_LO = 0;

  // conversion_setup fields
  localparam int CS_AVG_HI = 11;
  localparam int CS_AVG_LO = 10;
  localparam int CS_ACQ_HI = 9;
  localparam int CS_ACQ_LO = 8;
  localparam int CS_PM_HI = 7;
  localparam int CS_PM_LO = 6;
  localparam int CS_FCD_HI = 5;
  localparam int CS_FCD_LO = 4;
  localparam int CS_POL_BIT = 3;
  localparam int CS_REF_BIT = 2;
  localparam int CS_TMR_HI = 1;
  localparam int CS_TMR_LO = 0;

  // alert register: status in low nibble, enables at the top
  localparam int ALERT_EN_LO = 8;

  // conversion modes
  localparam logic [1:0] MODE_IDLE = 2'b00;
  localparam logic [1:0] MODE_SINGLE = 2'b01;
  localparam logic [1:0] MODE_SLAVE_SEQ = 2'b10;
  localparam logic [1:0] MODE_MASTER_SEQ = 2'b11;
  localparam logic [1:0] TMR_OFF = 2'b00;

  // channel codes
  localparam logic [CHAN_W-1:0] CHAN_SPARE_ONE = 4'h3;
  localparam logic [CHAN_W-1:0] CHAN_SPARE_TWO = 4'h4;
  localparam logic [CHAN_W-1:0] CHAN_SPARE_THREE = 4'h5;
  localparam logic [CHAN_W-1:0] CHAN_CELL_ONE = 4'h6;
  localparam logic [CHAN_W-1:0] CHAN_CELL_TWO = 4'h7;
  localparam logic [CHAN_W-1:0] CHAN_DIODE_ONE = 4'h8;
  localparam logic [CHAN_W-1:0] CHAN_LAST_VALID = 4'ha;

  // gap between repeated conversions when the timer is on
  localparam int REPEAT_GAP_CYCLES = 64;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_TOUCH,
    ST_CONVERT,
    ST_GAP
  } conv_state_e;
endpackage

// ### hw/results_store.sv
`timescale 1ns/1ps
`default_nettype none
// result memory with registered read data
module results_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // clock
  input wire logic clk_in,
  // write port
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  // read port
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule
`default_nettype wire

// ### hw/adc_control_limit_alarm.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - the cell inputs one and two use channels 0110b and 0111b and land in results 10110b and 10111b.
// - a cell input's halving divider is on only while that cell channel is being sampled.
// - spare inputs one to three use channels 0011b to 0101b and land in results 10011b to 10101b.
// - a new result of spare one, either cell or diode one is compared against its high and low limits.
// - an out-of-limit result sets its alert status bit and, when that bit's enable is set, drives the alarm pin.
// - high and low limits of the four watched channels are writable at addresses 00100b to 01011b.
// - the diode limit check uses the raw forward-voltage code as converted.
// - conversion_control holds the single/differential bit 11, channel, readback address and mode at the bottom.
// - conversion_setup holds averaging, sampling window, power, first delay, stop sense, reference and timer.
// - mode 00 is idle, 01 single channel, 10 slave sequence, 11 master sequence waiting for touch.
module adc_control_limit_alarm
  import adc_limit_pkg::*;
#(
  parameter int REPEAT_GAP = REPEAT_GAP_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // serial host port
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out,
  // pen touch pin
  input wire logic touch_in,
  // converter side
  output logic conv_start_out,
  output logic [CHAN_W-1:0] conv_channel_out,
  output logic conv_differential_out,
  input wire logic conv_done_in,
  input wire logic [DATA_W-1:0] conv_data_in,
  // setup fields to the analog side
  output logic [1:0] sample_averaging_count_out,
  output logic [1:0] sampling_window_length_out,
  output logic [1:0] power_management_field_out,
  output logic [1:0] initial_conversion_delay_out,
  output logic stop_signal_sense_out,
  output logic reference_select_out,
  output logic [1:0] repeat_interval_select_out,
  // cell dividers and alarm
  output logic [1:0] cell_divider_en_out,
  output logic alarm_out
);
  localparam int GAP_W = $clog2(REPEAT_GAP + 1);

  // maps a channel to its limit slot
  // bit 2 flags a watched channel, bits 1:0 pick its slot
  function automatic logic [2:0] limit_slot(input logic [CHAN_W-1:0] ch);
    case (ch)
      CHAN_SPARE_ONE: limit_slot = 3'b100;
      CHAN_CELL_ONE: limit_slot = 3'b101;
      CHAN_CELL_TWO: limit_slot = 3'b110;
      CHAN_DIODE_ONE: limit_slot = 3'b111;
      default: limit_slot = 3'b000;
    endcase
  endfunction

  // pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] mosi_sync;
  logic [1:0] touch_sync;
  logic sclk_prev;
  logic cs_prev;

  // registers
  logic [DATA_W-1:0] conversion_control;
  logic [DATA_W-1:0] conversion_setup;
  logic [DATA_W-1:0] limit_reg [2*SLOT_N];
  logic [SLOT_N-1:0] alert_status;
  logic [SLOT_N-1:0] alert_enable;

  // serial engine
  logic [FRAME_W-1:0] shift_in;
  logic [FRAME_W-1:0] shift_out;
  logic [4:0] bit_count;

  // conversion engine
  conv_state_e state;
  conv_state_e next_state;
  logic [GAP_W-1:0] gap_count;
  logic [DATA_W-1:0] result_rd;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cs_sync <= 2'b11;
      sclk_sync <= 2'b00;
      mosi_sync <= 2'b00;
      touch_sync <= 2'b00;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_in};
      sclk_sync <= {sclk_sync[0], sclk_in};
      mosi_sync <= {mosi_sync[0], mosi_in};
      touch_sync <= {touch_sync[0], touch_in};
      sclk_prev <= sclk_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  wire cs_active = !cs_sync[1];
  wire frame_start = cs_prev && !cs_sync[1];
  wire sclk_rise = cs_active && sclk_sync[1] && !sclk_prev;
  wire sclk_fall = cs_active && !sclk_sync[1] && sclk_prev;
  wire [FRAME_W-1:0] next_shift_in = {shift_in[FRAME_W-2:0], mosi_sync[1]};
  wire frame_done = sclk_rise && (bit_count == 5'(FRAME_W - 1));
  wire [WADDR_W-1:0] wr_addr = next_shift_in[FRAME_W-1:DATA_W];
  wire [DATA_W-1:0] wr_data = next_shift_in[DATA_W-1:0];
  wire wr_control = frame_done && (wr_addr == WADDR_CONV_CONTROL);
  wire wr_setup = frame_done && (wr_addr == WADDR_CONV_SETUP);
  wire wr_alert = frame_done && (wr_addr == WADDR_ALERT);
  wire wr_limit = frame_done && (wr_addr >= WADDR_LIMIT_FIRST) && (wr_addr <= WADDR_LIMIT_LAST);
  wire [2:0] wr_limit_idx = 3'(wr_addr - WADDR_LIMIT_FIRST);

  // field decode of conversion_control, plus the timer field of conversion_setup
  wire [1:0] mode = conversion_control[CC_MODE_HI:CC_MODE_LO];
  wire [CHAN_W-1:0] input_channel_code = conversion_control[CC_CHAN_HI:CC_CHAN_LO];
  wire [ADDR_W-1:0] readback_addr = conversion_control[CC_RDADDR_HI:CC_RDADDR_LO];
  wire single_vs_differential_select = conversion_control[CC_SERDIF_BIT];
  wire [1:0] timer_sel = conversion_setup[CS_TMR_HI:CS_TMR_LO];
  // channel codes above the last valid one never start
  wire channel_ok = input_channel_code <= CHAN_LAST_VALID;

  // readback source
  wire [4:0] rb_limit_idx = 5'(readback_addr - 5'(WADDR_LIMIT_FIRST));
  logic [DATA_W-1:0] rb_data;
  always_comb begin
    rb_data = '0;
    if (readback_addr >= RADDR_RESULT_BASE) begin
      rb_data = result_rd;
    end else if (readback_addr == 5'(WADDR_CONV_CONTROL)) begin
      rb_data = conversion_control;
    end else if (readback_addr == 5'(WADDR_CONV_SETUP)) begin
      rb_data = conversion_setup;
    end else if (readback_addr >= 5'(WADDR_LIMIT_FIRST) && readback_addr <= 5'(WADDR_LIMIT_LAST)) begin
      rb_data = limit_reg[rb_limit_idx[2:0]];
    end else if (readback_addr == 5'(WADDR_ALERT)) begin
      rb_data = {alert_enable, 4'h0, alert_status};
    end
  end

  // serial shifting; miso changes on falling sclk
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      shift_in <= '0;
      shift_out <= '0;
      bit_count <= '0;
      miso_out <= 1'b0;
    end else if (frame_start) begin
      bit_count <= '0;
      shift_out <= {4'h0, rb_data};
      miso_out <= 1'b0;
    end else if (!cs_active) begin
      bit_count <= '0;
    end else begin
      if (sclk_rise) begin
        shift_in <= next_shift_in;
        bit_count <= frame_done ? 5'd0 : bit_count + 5'd1;
      end
      if (sclk_fall) begin
        miso_out <= shift_out[FRAME_W-1];
        shift_out <= {shift_out[FRAME_W-2:0], 1'b0};
      end
    end
  end

  // conversion result path
  wire conv_ok = (state == ST_CONVERT) && conv_done_in;
  wire [ADDR_W-1:0] result_addr = {1'b1, conv_channel_out};
  wire [2:0] slot = limit_slot(conv_channel_out);
  wire watched = conv_ok && slot[2];
  wire [DATA_W-1:0] high_limit = limit_reg[{slot[1:0], 1'b0}];
  wire [DATA_W-1:0] low_limit = limit_reg[{slot[1:0], 1'b1}];
  // raw diode code compared, no conversion to degrees
  wire out_of_limit = (conv_data_in > high_limit) || (conv_data_in < low_limit);
  wire [SLOT_N-1:0] alert_set = (watched && out_of_limit) ? (SLOT_N'(1) << slot[1:0]) : '0;
  // writing one clears a status bit; a new set in that cycle wins
  wire [SLOT_N-1:0] alert_clr = wr_alert ? wr_data[SLOT_N-1:0] : '0;
  wire [SLOT_N-1:0] next_alert_status = (alert_status & ~alert_clr) | alert_set;

  results_store #(.WIDTH(DATA_W), .DEPTH(1 << ADDR_W), .AW(ADDR_W)) u_results (
    .clk_in(ref_clk_in),
    .wr_en_in(conv_ok),
    .wr_addr_in(result_addr),
    .wr_data_in(conv_data_in),
    .rd_addr_in(readback_addr),
    .rd_data_out(result_rd)
  );

  // conversion state machine
  wire start_now = (mode == MODE_MASTER_SEQ) ? touch_sync[1] : 1'b1;
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (mode == MODE_MASTER_SEQ) begin
          next_state = ST_WAIT_TOUCH;
        end else if (mode != MODE_IDLE && channel_ok) begin
          next_state = ST_CONVERT;
        end
      end
      ST_WAIT_TOUCH: begin
        if (start_now && channel_ok) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (conv_done_in) begin
          next_state = (timer_sel == TMR_OFF && mode != MODE_MASTER_SEQ) ? ST_IDLE : ST_GAP;
        end
      end
      ST_GAP: begin
        if (gap_count == GAP_W'(REPEAT_GAP)) begin
          next_state = (mode == MODE_MASTER_SEQ) ? ST_WAIT_TOUCH : ST_CONVERT;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // writing mode 00 stops everything
    if (mode == MODE_IDLE) begin
      next_state = ST_IDLE;
    end
  end

  wire enter_convert = (next_state == ST_CONVERT) && (state != ST_CONVERT);
  wire single_finished = conv_ok && (timer_sel == TMR_OFF) && (mode != MODE_MASTER_SEQ);

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      gap_count <= '0;
      conv_start_out <= 1'b0;
      conv_channel_out <= '0;
      conv_differential_out <= 1'b0;
      cell_divider_en_out <= 2'b00;
    end else begin
      // any control write restarts the engine
      state <= wr_control ? ST_IDLE : next_state;
      gap_count <= (state == ST_GAP) ? gap_count + GAP_W'(1) : '0;
      conv_start_out <= enter_convert && !wr_control;
      if (enter_convert) begin
        conv_channel_out <= input_channel_code;
        conv_differential_out <= single_vs_differential_select;
      end
      // divider on only while a cell channel is in conversion
      cell_divider_en_out[0] <= (next_state == ST_CONVERT) && !wr_control
        && ((enter_convert ? input_channel_code : conv_channel_out) == CHAN_CELL_ONE);
      cell_divider_en_out[1] <= (next_state == ST_CONVERT) && !wr_control
        && ((enter_convert ? input_channel_code : conv_channel_out) == CHAN_CELL_TWO);
    end
  end

  // register file
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      conversion_control <= CONV_CONTROL_RESET;
      conversion_setup <= CONV_SETUP_RESET;
      alert_status <= '0;
      alert_enable <= '0;
      alarm_out <= 1'b0;
      for (int i = 0; i < 2 * SLOT_N; i++) begin
        limit_reg[i] <= LIMIT_RESET;
      end
    end else begin
      if (wr_control) begin
        conversion_control <= wr_data;
      end else if (single_finished) begin
        conversion_control[CC_MODE_HI:CC_MODE_LO] <= MODE_IDLE;
      end
      if (wr_setup) begin
        conversion_setup <= wr_data;
      end
      if (wr_limit) begin
        limit_reg[wr_limit_idx] <= wr_data;
      end
      if (wr_alert) begin
        alert_enable <= wr_data[ALERT_EN_LO +: SLOT_N];
      end
      alert_status <= next_alert_status;
      alarm_out <= |(next_alert_status & (wr_alert ? wr_data[ALERT_EN_LO +: SLOT_N] : alert_enable));
    end
  end

  // setup fields to the analog side
  assign sample_averaging_count_out = conversion_setup[CS_AVG_HI:CS_AVG_LO];
  assign sampling_window_length_out = conversion_setup[CS_ACQ_HI:CS_ACQ_LO];
  assign power_management_field_out = conversion_setup[CS_PM_HI:CS_PM_LO];
  assign initial_conversion_delay_out = conversion_setup[CS_FCD_HI:CS_FCD_LO];
  assign stop_signal_sense_out = conversion_setup[CS_POL_BIT];
  assign reference_select_out = conversion_setup[CS_REF_BIT];
  assign repeat_interval_select_out = timer_sel;

endmodule
`default_nettype wire

// ### dv/host_serial_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the serial port: sclk idles low, stands still outside frames
module host_serial_model #(
  parameter int HALF = 5
) (
  input wire logic clk_in,
  input wire logic miso_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // one 16-bit frame, msb first; readback bits change after falling sclk
  task automatic frame(input logic [15:0] word, output logic [15:0] rd);
    step(1);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      step(HALF);
      mosi_out = word[i];
      step(HALF);
      sclk_out = 1'b1;
      // miso runs one bit behind, so it shows bit i+1 here
      if (i < 15) begin
        rd[i + 1] = miso_in;
      end
      step(HALF);
      sclk_out = 1'b0;
    end
    step(HALF);
    rd[0] = miso_in;
    cs_n_out = 1'b1;
    // released line shows the inverse of the last bit
    mosi_out = ~mosi_out;
    step(HALF);
  endtask
endmodule
`default_nettype wire

// ### dv/adc_limit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adc_limit_properties
  import adc_limit_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic cs_n_in,
  input wire logic conv_start_out,
  input wire logic [CHAN_W-1:0] conv_channel_out,
  input wire logic conv_done_in,
  input wire logic [1:0] sample_averaging_count_out,
  input wire logic stop_signal_sense_out,
  input wire logic [1:0] repeat_interval_select_out,
  input wire logic [1:0] cell_divider_en_out,
  input wire logic alarm_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  chk_start_pulse: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse longer than one cycle");
  chk_start_valid: assert property (conv_start_out |-> conv_channel_out <= CHAN_LAST_VALID)
    else $error("conversion started on invalid channel");
  chk_div_one_chan: assert property (cell_divider_en_out[0] |-> conv_channel_out == CHAN_CELL_ONE)
    else $error("cell one divider on for other channel");
  chk_div_two_chan: assert property (cell_divider_en_out[1] |-> conv_channel_out == CHAN_CELL_TWO)
    else $error("cell two divider on for other channel");
  chk_div_at_start: assert property (conv_start_out && conv_channel_out == CHAN_CELL_TWO
    |-> cell_divider_en_out == 2'b10)
    else $error("cell two divider not on at start");
  chk_div_off_done: assert property (conv_done_in |=> cell_divider_en_out == 2'b00)
    else $error("divider still on after conversion");
  chk_alarm_hold: assert property (cs_n_in [*8] ##0 alarm_out |=> alarm_out)
    else $error("alarm dropped without a host write");
  chk_reset_quiet: assert property (disable iff (1'b0) !rstn_in
    |=> !alarm_out && !conv_start_out && cell_divider_en_out == 2'b00)
    else $error("outputs active after reset");
  chk_setup_zero: assert property ($rose(rstn_in)
    |-> {sample_averaging_count_out, stop_signal_sense_out, repeat_interval_select_out} == 5'h00)
    else $error("setup fields not zero after reset");

  cover property (conv_start_out);
  cover property (conv_done_in && cell_divider_en_out[1]);
  cover property ($rose(alarm_out));
endmodule

bind adc_control_limit_alarm adc_limit_properties u_props (
  .ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in),
  .cs_n_in(cs_n_in),
  .conv_start_out(conv_start_out),
  .conv_channel_out(conv_channel_out),
  .conv_done_in(conv_done_in),
  .sample_averaging_count_out(sample_averaging_count_out),
  .stop_signal_sense_out(stop_signal_sense_out),
  .repeat_interval_select_out(repeat_interval_select_out),
  .cell_divider_en_out(cell_divider_en_out),
  .alarm_out(alarm_out)
);
`default_nettype wire

// ### dv/test_adc_control_limit_alarm.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_limit_alarm;
  import adc_limit_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic touch = 1'b0;
  logic done = 1'b0;
  logic [DATA_W-1:0] data = 12'h000;
  logic cs_n, sclk, mosi, miso, start, diff, alarm, stop_signal_sense, refs, st_diff;
  logic [CHAN_W-1:0] chan, st_chan;
  logic [1:0] sample_averaging_count, sampling_window_length, pm, fcd, tmr, div, st_div;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int starts = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;

  adc_control_limit_alarm #(.REPEAT_GAP(4)) u_dut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .sclk_in(sclk), .mosi_in(mosi),
    .miso_out(miso), .touch_in(touch), .conv_start_out(start), .conv_channel_out(chan),
    .conv_differential_out(diff), .conv_done_in(done), .conv_data_in(data),
    .sample_averaging_count_out(sample_averaging_count), .sampling_window_length_out(sampling_window_length), .power_management_field_out(pm),
    .initial_conversion_delay_out(fcd), .stop_signal_sense_out(stop_signal_sense), .reference_select_out(refs),
    .repeat_interval_select_out(tmr), .cell_divider_en_out(div), .alarm_out(alarm)
  );
  host_serial_model u_host (.clk_in(ref_clk_in), .miso_in(miso), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (start === 1'b1) begin
      starts <= starts + 1;
      st_chan <= chan;
      st_div <= div;
      st_diff <= diff;
    end
    if (cycles == 30000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    logic [15:0] v;
    u_host.frame({a, d}, v);
  endtask

  // set readback address with mode idle, then fetch with a no-op frame
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    u_host.frame({WADDR_CONV_CONTROL, 1'b0, 4'h0, a, MODE_IDLE}, v);
    u_host.frame(16'h0000, v);
  endtask

  task automatic convert(input logic [3:0] c, input logic [11:0] d, input logic [1:0] dv);
    logic [15:0] v;
    int n0;
    n0 = starts;
    wr(WADDR_CONV_CONTROL, {c[0], c, 1'b1, c, MODE_SINGLE});
    check("start count", 16'(n0 + 1), 16'(starts));
    check("start channel", {12'h000, c}, {12'h000, st_chan});
    check("differential", {15'h0000, c[0]}, {15'h0000, st_diff});
    check("divider at start", {14'h0000, dv}, {14'h0000, st_div});
    done = 1'b1;
    data = d;
    step(1);
    done = 1'b0;
    step(2);
    check("divider after done", 16'h0000, {14'h0000, div});
    u_host.frame(16'h0000, v);
    check("result", {4'h0, d}, v);
    check("no repeat", 16'(n0 + 1), 16'(starts));
  endtask

  task automatic test_regs();
    logic [15:0] v;
    rd_reg(5'h02, v);
    check("setup reset", 16'h0000, v);
    wr(WADDR_CONV_SETUP, 12'ha5c);
    check("setup fields", 16'h0a5c, {4'h0, sample_averaging_count, sampling_window_length, pm, fcd, stop_signal_sense, refs, tmr});
    rd_reg(5'h02, v);
    check("setup read", 16'h0a5c, v);
    rd_reg(5'h01, v);
    check("control read", 16'h0004, v);
    rd_reg(5'h0d, v);
    check("unmapped read", 16'h0000, v);
    $display("test_regs done");
  endtask

  task automatic test_map();
    for (int c = 3; c <= 8; c++) begin
      convert(4'(c), 12'(12'h100 + c), (c == 6) ? 2'b01 : (c == 7) ? 2'b10 : 2'b00);
    end
    $display("test_map done");
  endtask

  task automatic test_limits();
    logic [15:0] v;
    wr(WADDR_ALERT, 12'h00f);
    wr(4'h4, 12'h800);
    wr(4'h5, 12'h100);
    wr(4'ha, 12'h300);
    wr(4'hb, 12'h200);
    wr(WADDR_ALERT, 12'hf00);
    rd_reg(5'h04, v);
    check("limit read", 16'h0800, v);
    convert(CHAN_SPARE_ONE, 12'h800, 2'b00);
    convert(CHAN_SPARE_ONE, 12'h100, 2'b00);
    check("alarm at bounds", 16'h0000, {15'h0000, alarm});
    convert(CHAN_DIODE_ONE, 12'h1ff, 2'b00);
    check("alarm diode low", 16'h0001, {15'h0000, alarm});
    rd_reg(5'h0c, v);
    check("alert status", 16'h0f08, v);
    convert(CHAN_SPARE_ONE, 12'h400, 2'b00);
    check("alarm sticky", 16'h0001, {15'h0000, alarm});
    wr(WADDR_ALERT, 12'hf08);
    check("alarm cleared", 16'h0000, {15'h0000, alarm});
    $display("test_limits done");
  endtask

  task automatic test_touch();
    logic [15:0] v;
    int n0;
    n0 = starts;
    wr(WADDR_CONV_CONTROL, {1'b0, 4'hb, 5'h00, MODE_SINGLE});
    step(4);
    check("bad channel", 16'(n0), 16'(starts));
    wr(WADDR_CONV_CONTROL, {1'b0, CHAN_SPARE_TWO, 1'b1, CHAN_SPARE_TWO, MODE_MASTER_SEQ});
    step(8);
    check("wait for touch", 16'(n0), 16'(starts));
    touch = 1'b1;
    step(6);
    check("touch start", 16'(n0 + 1), 16'(starts));
    check("touch channel", {12'h000, CHAN_SPARE_TWO}, {12'h000, st_chan});
    done = 1'b1;
    data = 12'h0c4;
    step(1);
    done = 1'b0;
    touch = 1'b0;
    step(12);
    check("no start untouched", 16'(n0 + 1), 16'(starts));
    u_host.frame(16'h0000, v);
    check("touch result", 16'h00c4, v);
    wr(WADDR_CONV_CONTROL, {1'b0, CHAN_SPARE_TWO, 1'b1, CHAN_SPARE_TWO, MODE_IDLE});
    $display("test_touch done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    step(12);
    rstn_in = 1'b1;
    step(3);
    test_regs();
    test_map();
    test_limits();
    test_touch();
    stop_test();
  end
endmodule
`default_nettype wire
